// ---- verilog/qcc_pkg.sv ----
// Package of register map, field positions and mode codes for the encoder counter control.
package qcc_pkg;
  // ****************************************
  // Register bus geometry
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_POS = 4'h1;
  localparam logic [3:0] ADDR_INIT = 4'h2;
  localparam logic [3:0] ADDR_GE = 4'h3;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  // ****************************************
  // Control register fields and reset value
  // ****************************************
  localparam int BIT_EN = 15;
  localparam int BIT_IDLE = 13;
  localparam int MODE_HI = 12;
  localparam int MODE_LO = 10;
  localparam int BIT_MATCH_B = 9;
  localparam int BIT_MATCH_A = 8;
  localparam logic [15:0] CTRL_MASK = 16'hBF00;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // ****************************************
  // Status register fields
  // ****************************************
  localparam int STAT_RUN = 0;
  localparam int STAT_ARMED = 1;
  localparam int STAT_FIRST = 2;
  // ****************************************
  // Position counter initialisation modes
  // ****************************************
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_IDX_RST = 3'h1;
  localparam logic [2:0] MODE_IDX_LOAD = 3'h2;
  localparam logic [2:0] MODE_HOME_1ST = 3'h3;
  localparam logic [2:0] MODE_HOME_2ND = 3'h4;
  localparam logic [2:0] MODE_GE_RST = 3'h5;
  localparam logic [2:0] MODE_MODULO = 3'h6;
  // ****************************************
  // Home tracking states
  // ****************************************
  typedef enum logic [1:0] {HOME_IDLE, HOME_ARMED, HOME_FIRST} qcc_home_t;
endpackage

// ---- verilog/qcc_sync.sv ----
// Two-stage synchroniser for a group of encoder pins.
`timescale 1ns/1ps
`default_nettype none
module qcc_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Pins and synchronised copies.
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync = sync_ff;
endmodule
`default_nettype wire

// ---- verilog/qcc_quad_dec.sv ----
// Quadrature decoder giving one count step per phase edge and the index and home edges.
`timescale 1ns/1ps
`default_nettype none
module qcc_quad_dec (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Synchronised encoder levels.
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic index_in,
  input wire logic home_in,
  // Decoded events and phase levels, registered.
  output logic step_ff,
  output logic up_ff,
  output logic index_rise_ff,
  output logic home_rise_ff,
  output logic a_lvl_ff,
  output logic b_lvl_ff
);
  logic pa_ff;
  logic pb_ff;
  logic pidx_ff;
  logic phome_ff;
  wire step = (phase_a ^ pa_ff) ^ (phase_b ^ pb_ff);
  wire dir_up = phase_a ^ pb_ff;

  // A single phase change is one step; a double change is a glitch and ignored.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
      pidx_ff <= 1'b0;
      phome_ff <= 1'b0;
      step_ff <= 1'b0;
      up_ff <= 1'b0;
      index_rise_ff <= 1'b0;
      home_rise_ff <= 1'b0;
      a_lvl_ff <= 1'b0;
      b_lvl_ff <= 1'b0;
    end else begin
      pa_ff <= phase_a;
      pb_ff <= phase_b;
      pidx_ff <= index_in;
      phome_ff <= home_in;
      step_ff <= step;
      up_ff <= dir_up;
      index_rise_ff <= index_in & ~pidx_ff;
      home_rise_ff <= home_in & ~phome_ff;
      a_lvl_ff <= phase_a;
      b_lvl_ff <= phase_b;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/qcc_counter_ctl.sv ----
// Encoder counter control: register file, position counter and its initialisation modes.
`timescale 1ns/1ps
`default_nettype none
module qcc_counter_ctl #(
  parameter int POS_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic [qcc_pkg::ADDR_W-1:0] addr,
  input wire logic [qcc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [qcc_pkg::DATA_W-1:0] rdata,
  // System idle request, same clock.
  input wire logic idle_req,
  // Encoder pins.
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic home_input,
  // Position count.
  output logic [POS_W-1:0] pos_value
);
  import qcc_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (POS_W < 2 || POS_W > DATA_W) begin : g_bad_w
      $error("POS_W must lie between 2 and the data width");
    end
  endgenerate

  // ****************************************
  // Pin synchronisation and decoding
  // ****************************************
  logic [3:0] pins_sync;
  logic step;
  logic up;
  logic idx_rise;
  logic home_rise;
  logic a_lvl;
  logic b_lvl;

  qcc_sync #(.W(4)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in({home_input, index_input, phase_b_input, phase_a_input}),
    .pin_sync(pins_sync)
  );

  qcc_quad_dec u_dec (
    .clk(clk),
    .nrst(nrst),
    .phase_a(pins_sync[0]),
    .phase_b(pins_sync[1]),
    .index_in(pins_sync[2]),
    .home_in(pins_sync[3]),
    .step_ff(step),
    .up_ff(up),
    .index_rise_ff(idx_rise),
    .home_rise_ff(home_rise),
    .a_lvl_ff(a_lvl),
    .b_lvl_ff(b_lvl)
  );

  // ****************************************
  // Register file
  // ****************************************
  logic [DATA_W-1:0] ctrl_ff;
  logic [POS_W-1:0] init_ff;
  logic [POS_W-1:0] ge_ff;
  logic [POS_W-1:0] pos_ff;
  logic [POS_W-1:0] nxt_pos;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  qcc_home_t home_ff;
  qcc_home_t nxt_home;

  // Pads a position-width value into a data word.
  function automatic logic [DATA_W-1:0] widen(input logic [POS_W-1:0] v);
    widen = '0;
    widen[POS_W-1:0] = v;
  endfunction

  // Address decode of the write strobe.
  wire wr_ctrl = wr && (addr == ADDR_CTRL);
  wire wr_pos = wr && (addr == ADDR_POS);
  wire wr_init = wr && (addr == ADDR_INIT);
  wire wr_ge = wr && (addr == ADDR_GE);

  // Control fields.
  wire en = ctrl_ff[BIT_EN];
  wire idle_stop = ctrl_ff[BIT_IDLE];
  wire [2:0] mode = ctrl_ff[MODE_HI:MODE_LO];
  wire match_b = ctrl_ff[BIT_MATCH_B];
  wire match_a = ctrl_ff[BIT_MATCH_A];

  // Counters run when enabled and not held by idle.
  wire run = en && !(idle_stop && idle_req);

  // An index event counts only on the chosen phase levels.
  wire idx_ev = run && idx_rise && (b_lvl == match_b) && (a_lvl == match_a);

  // Registers stay writable whatever the enable state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RST;
      init_ff <= '0;
      ge_ff <= '0;
    end else begin
      if (wr_ctrl) ctrl_ff <= wdata & CTRL_MASK;
      if (wr_init) init_ff <= wdata[POS_W-1:0];
      if (wr_ge) ge_ff <= wdata[POS_W-1:0];
    end
  end

  // Read mux; unmapped addresses read zero and data stand one cycle only.
  always_comb begin
    nxt_rdata = DATA_RST;
    if (rd) begin
      case (addr)
        ADDR_CTRL: nxt_rdata = ctrl_ff;
        ADDR_POS: nxt_rdata = widen(pos_ff);
        ADDR_INIT: nxt_rdata = widen(init_ff);
        ADDR_GE: nxt_rdata = widen(ge_ff);
        ADDR_STAT: begin
          nxt_rdata[STAT_RUN] = run;
          nxt_rdata[STAT_ARMED] = (home_ff == HOME_ARMED);
          nxt_rdata[STAT_FIRST] = (home_ff == HOME_FIRST);
        end
        default: nxt_rdata = DATA_RST;
      endcase
    end
  end

  // ****************************************
  // Home and index tracking
  // ****************************************
  wire home_mode = (mode == MODE_HOME_1ST) || (mode == MODE_HOME_2ND);

  // Home arms the tracker; index events then walk it to the load point.
  always_comb begin
    nxt_home = home_ff;
    if (!home_mode) begin
      nxt_home = HOME_IDLE;
    end else if (run) begin
      case (home_ff)
        HOME_IDLE: begin
          if (home_rise) nxt_home = HOME_ARMED;
        end
        HOME_ARMED: begin
          if (idx_ev) nxt_home = (mode == MODE_HOME_2ND) ? HOME_FIRST : HOME_IDLE;
        end
        HOME_FIRST: begin
          if (idx_ev) nxt_home = HOME_IDLE;
        end
        default: nxt_home = HOME_IDLE;
      endcase
    end
  end

  // Load points of the home modes.
  wire load_1st = (mode == MODE_HOME_1ST) && (home_ff == HOME_ARMED) && idx_ev;
  wire load_2nd = (mode == MODE_HOME_2ND) && (home_ff == HOME_FIRST) && idx_ev;

  // ****************************************
  // Position counter
  // ****************************************
  wire at_ge = (pos_ff == ge_ff);
  wire at_zero = (pos_ff == '0);

  // Software write wins, then initialisation, then the count step.
  always_comb begin
    nxt_pos = pos_ff;
    if (run) begin
      if (step) begin
        nxt_pos = up ? pos_ff + 1'b1 : pos_ff - 1'b1;
        if (mode == MODE_MODULO) begin
          if (up && at_ge) nxt_pos = '0;
          if (!up && at_zero) nxt_pos = ge_ff;
        end
      end
      case (mode)
        MODE_NONE: ;
        MODE_IDX_RST: begin
          if (idx_ev) nxt_pos = '0;
        end
        MODE_IDX_LOAD: begin
          if (idx_ev) nxt_pos = init_ff;
        end
        MODE_HOME_1ST: begin
          if (load_1st) nxt_pos = init_ff;
        end
        MODE_HOME_2ND: begin
          if (load_2nd) nxt_pos = init_ff;
        end
        MODE_GE_RST: begin
          if (at_ge) nxt_pos = '0;
        end
        default: ;
      endcase
    end
    if (wr_pos) nxt_pos = wdata[POS_W-1:0];
  end

  // State registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos_ff <= '0;
      home_ff <= HOME_IDLE;
      rdata_ff <= DATA_RST;
    end else begin
      pos_ff <= nxt_pos;
      home_ff <= nxt_home;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;
  assign pos_value = pos_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Control write followed by read of the same register.
  sequence s_ctrl_wr;
    wr_ctrl ##1 (rd && addr == ADDR_CTRL && !wr);
  endsequence

  // Home edge seen while the tracker waits in a home mode.
  sequence s_home_arm;
    home_mode && run && home_ff == HOME_IDLE && home_rise && !wr_ctrl;
  endsequence

  // Qualified index while armed in the first-index mode.
  sequence s_first_load;
    mode == MODE_HOME_1ST && home_ff == HOME_ARMED && idx_ev
      && !wr_pos && !wr_init && !wr_ctrl;
  endsequence

  // Enable gating of the counters.
  hold_disabled_a: assert property (!en && !wr_pos |=> $stable(pos_ff))
    else $error("position moved while disabled");
  // Register readback and read data lifetime.
  ctrl_readback_a: assert property (s_ctrl_wr |=> rdata == ($past(wdata, 2) & CTRL_MASK))
    else $error("control readback wrong");
  rd_clear_a: assert property (!rd |=> rdata == DATA_RST)
    else $error("read data stood without a read");
  // Idle handling.
  idle_halt_a: assert property (en && idle_stop && idle_req && !wr_pos |=> $stable(pos_ff))
    else $error("counting during idle stop");
  idle_run_a: assert property (en && !idle_stop && step && up && mode == MODE_NONE && !wr_pos
    |=> pos_ff == $past(pos_ff) + 1'b1)
    else $error("count lost in idle without stop");
  // Initialisation modes.
  modulo_wrap_a: assert property (run && mode == MODE_MODULO && step && up && at_ge && !wr_pos
    |=> pos_ff == '0)
    else $error("modulo wrap missed");
  modulo_down_a: assert property (run && mode == MODE_MODULO && step && !up && at_zero
    && !wr_pos |=> pos_ff == $past(ge_ff))
    else $error("modulo underflow wrap missed");
  ge_reset_a: assert property (run && mode == MODE_GE_RST && at_ge && !wr_pos |=> pos_ff == '0)
    else $error("compare reset missed");
  idx_reset_a: assert property (mode == MODE_IDX_RST && idx_ev && !wr_pos |=> pos_ff == '0)
    else $error("index reset missed");
  idx_load_a: assert property (mode == MODE_IDX_LOAD && idx_ev && !wr_pos && !wr_init
    |=> pos_ff == $past(init_ff))
    else $error("index load missed");
  home_arm_a: assert property (s_home_arm |=> home_ff == HOME_ARMED)
    else $error("home edge did not arm tracker");
  home_first_a: assert property (s_first_load
    |=> pos_ff == $past(init_ff) && home_ff == HOME_IDLE)
    else $error("first index after home not loaded");
  home_second_a: assert property (mode == MODE_HOME_2ND && home_ff == HOME_ARMED && idx_ev
    && !wr_ctrl |=> home_ff == HOME_FIRST && !load_2nd)
    else $error("second index tracking wrong");
  no_idx_a: assert property (run && mode == MODE_NONE && idx_rise && !step && !wr_pos
    |=> $stable(pos_ff))
    else $error("index moved position in mode zero");
  // Index qualification on the phase levels.
  qual_levels_a: assert property (run && mode == MODE_IDX_RST && idx_rise && !step
    && !wr_pos && (a_lvl != match_a || b_lvl != match_b) |=> $stable(pos_ff))
    else $error("unqualified index accepted");
endmodule
`default_nettype wire

// ---- tb/qcc_enc_model.sv ----
// Behavioural incremental encoder with phase, index and home outputs.
`timescale 1ns/1ps
`default_nettype none
module qcc_enc_model (
  // Clock.
  input wire logic clk,
  // Encoder pins.
  output logic phase_a,
  output logic phase_b,
  output logic index_out,
  output logic home_out
);
  logic [1:0] st;

  // Pins start low, in quadrature state zero.
  initial begin
    st = 2'h0;
    phase_a = 1'b0;
    phase_b = 1'b0;
    index_out = 1'b0;
    home_out = 1'b0;
  end

  // Moves one Gray state and holds it four cycles, so only one phase changes.
  task automatic step(input bit up);
    begin
      @(posedge clk);
      st = up ? st + 2'h1 : st - 2'h1;
      phase_a <= st[0] ^ st[1];
      phase_b <= st[1];
      repeat (4) @(posedge clk);
    end
  endtask

  // Gives a four-cycle pulse on index (sel 0) or home (sel 1).
  task automatic pulse(input bit sel);
    begin
      @(posedge clk);
      if (sel) home_out <= 1'b1;
      else index_out <= 1'b1;
      repeat (4) @(posedge clk);
      home_out <= 1'b0;
      index_out <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/qcc_counter_ctl_tb.sv ----
// Self-checking bench for the encoder counter control.
`timescale 1ns/1ps
`default_nettype none
module qcc_counter_ctl_tb;
  import qcc_pkg::*;
  logic clk, nrst, wr, rd, idle_req;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, pos_value;
  wire logic pa, pb, idx, home;
  int fail_count = 0;
  int samples_checked = 0;

  // ****************************************
  // Instances
  // ****************************************
  qcc_counter_ctl #(.POS_W(16)) i_dut (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .idle_req(idle_req),
    .phase_a_input(pa), .phase_b_input(pb), .index_input(idx), .home_input(home),
    .pos_value(pos_value));
  qcc_enc_model i_enc (.clk(clk), .phase_a(pa), .phase_b(pb), .index_out(idx),
    .home_out(home));

  // ****************************************
  // Tasks
  // ****************************************
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Write strobe followed at once by a read strobe of the same address.
  task automatic wr_rd_chk(input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp,
    input string nm);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask

  // One-cycle read strobe, data taken in the following cycle.
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask

  // Lets the pin pipeline settle, then checks the position.
  task automatic chk_pos(input logic [15:0] exp);
    repeat (3) @(posedge clk);
    #1;
    chk("pos_value", pos_value, exp);
  endtask

  // Several steps in one direction.
  task automatic steps(input int n, input bit up);
    repeat (n) i_enc.step(up);
  endtask

  // Prints counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and test sequence
  // ****************************************
  // Clock of 10 ns period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short well beyond the expected run time.
  initial begin
    #300000;
    fail_count++;
    end_sim();
  end

  // Main sequence.
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    idle_req = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(ADDR_CTRL, CTRL_RST, "ctrl reset");
    wr_reg(ADDR_CTRL, 16'h7BFF);
    rd_chk(ADDR_CTRL, 16'h3B00, "ctrl mask");
    wr_reg(ADDR_CTRL, 16'h0000);
    wr_reg(4'hF, 16'hFFFF);
    rd_chk(4'hF, 16'h0000, "unmapped");
    rd_chk(ADDR_CTRL, 16'h0000, "ctrl kept");
    steps(2, 1'b1);
    chk_pos(16'h0000);
    rd_chk(ADDR_STAT, 16'h0000, "stat off");
    wr_reg(ADDR_POS, 16'h0010);
    wr_reg(ADDR_INIT, 16'h0055);
    wr_reg(ADDR_GE, 16'h0003);
    rd_chk(ADDR_POS, 16'h0010, "pos reg");
    rd_chk(ADDR_INIT, 16'h0055, "init reg");
    rd_chk(ADDR_GE, 16'h0003, "ge reg");
    steps(2, 1'b0);
    chk_pos(16'h0010);
    wr_rd_chk(ADDR_CTRL, 16'hC000, 16'h8000, "ctrl enable");
    rd_chk(ADDR_STAT, 16'h0001, "stat run");
    steps(4, 1'b1);
    chk_pos(16'h0014);
    i_enc.pulse(1'b0);
    chk_pos(16'h0014);
    steps(2, 1'b0);
    chk_pos(16'h0012);
    steps(2, 1'b1);
    wr_reg(ADDR_CTRL, 16'hA000);
    idle_req <= 1'b1;
    steps(4, 1'b1);
    chk_pos(16'h0014);
    rd_chk(ADDR_STAT, 16'h0000, "stat held");
    wr_reg(ADDR_CTRL, 16'h8000);
    steps(4, 1'b1);
    chk_pos(16'h0018);
    idle_req <= 1'b0;
    wr_reg(ADDR_CTRL, 16'h8600);
    i_enc.pulse(1'b0);
    chk_pos(16'h0018);
    wr_reg(ADDR_CTRL, 16'h8500);
    i_enc.pulse(1'b0);
    chk_pos(16'h0018);
    wr_reg(ADDR_CTRL, 16'h8400);
    i_enc.pulse(1'b0);
    chk_pos(16'h0000);
    steps(2, 1'b1);
    wr_reg(ADDR_CTRL, 16'h8700);
    i_enc.pulse(1'b0);
    chk_pos(16'h0000);
    steps(2, 1'b0);
    chk_pos(16'hFFFE);
    wr_reg(ADDR_CTRL, 16'h8800);
    i_enc.pulse(1'b0);
    chk_pos(16'h0055);
    wr_reg(ADDR_POS, 16'h0000);
    wr_reg(ADDR_CTRL, 16'h8C00);
    i_enc.pulse(1'b0);
    chk_pos(16'h0000);
    i_enc.pulse(1'b1);
    rd_chk(ADDR_STAT, 16'h0003, "stat armed");
    i_enc.pulse(1'b0);
    chk_pos(16'h0055);
    wr_reg(ADDR_POS, 16'h0000);
    wr_reg(ADDR_CTRL, 16'h9000);
    i_enc.pulse(1'b1);
    i_enc.pulse(1'b0);
    chk_pos(16'h0000);
    rd_chk(ADDR_STAT, 16'h0005, "stat first");
    i_enc.pulse(1'b0);
    chk_pos(16'h0055);
    rd_chk(ADDR_STAT, 16'h0001, "stat done");
    wr_reg(ADDR_POS, 16'h0000);
    wr_reg(ADDR_CTRL, 16'h9400);
    steps(3, 1'b1);
    chk_pos(16'h0000);
    wr_reg(ADDR_CTRL, 16'h9800);
    wr_reg(ADDR_POS, 16'h0003);
    i_enc.step(1'b1);
    chk_pos(16'h0000);
    i_enc.step(1'b0);
    chk_pos(16'h0003);
    i_enc.step(1'b0);
    chk_pos(16'h0002);
    end_sim();
  end
endmodule
`default_nettype wire
